// >>> design/imx_pkg.sv
package imx_pkg;
	localparam int unsigned IMX_BYTE_W = 8;
	localparam int unsigned IMX_FIFO_DEPTH = 8;
	localparam logic [3:0] IMX_BIT_LAST = 4'h7;
	localparam logic [3:0] IMX_BIT_ACK = 4'h8;
	localparam logic [7:0] IMX_BRG_ZERO = 8'h00;
	localparam logic [7:0] IMX_BYTE_RST = 8'h00;
	localparam logic [3:0] IMX_CNT_RST = 4'h0;
	typedef enum logic [3:0] {
		IMX_IDLE,
		IMX_TX_LOW,
		IMX_TX_HIGH,
		IMX_TX_WAIT,
		IMX_RX_LOW,
		IMX_RX_HIGH,
		IMX_ACK_LOW,
		IMX_ACK_HIGH,
		IMX_STOP_SDA,
		IMX_STOP_LOW,
		IMX_STOP_HIGH,
		IMX_STOP_REL,
		IMX_STOP_END
	} imx_state_t;
endpackage

// >>> design/imx_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module imx_fifo #(
	parameter int unsigned WIDTH = 8,
	parameter int unsigned DEPTH = 8
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [WIDTH-1:0] in_data_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	output logic [WIDTH-1:0] out_data_o,
	output logic out_valid_o,
	input wire logic out_ready_i
);
	localparam int unsigned AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wr_q;
	logic [AW-1:0] rd_q;
	logic [AW:0] cnt_q;
	logic [AW:0] cnt_d;
	logic push;
	logic pop;
	assign out_valid_o = (cnt_q != '0);
	assign cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
	assign out_data_o = mem_q[rd_q];
	assign push = in_valid_i && in_ready_o;
	assign pop = out_valid_o && out_ready_i;
	always_ff @(posedge clk_i) begin
		if (push) begin
			mem_q[wr_q] <= in_data_i;
		end
	end
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
			in_ready_o <= 1'b1;
		end else begin
			// ready is registered from the next count so the port comes off a flop
			in_ready_o <= (cnt_d != (AW+1)'(DEPTH));
			if (push) begin
				wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + AW'(1);
			end
			if (pop) begin
				rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + AW'(1);
			end
			cnt_q <= cnt_d;
		end
	end
endmodule // imx_fifo
`default_nettype wire

// >>> design/imx_master.sv
`timescale 1ns/1ps
`default_nettype none
module imx_master
	import imx_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [7:0] wr_data_i,
	input wire logic wr_valid_i,
	output logic wr_ready_o,
	input wire logic buf_rd_i,
	output logic [7:0] tx_rx_buffer_o,
	input wire logic [7:0] baud_reload_value_i,
	input wire logic receive_request_set_i,
	input wire logic ack_sequence_request_set_i,
	input wire logic stop_request_set_i,
	input wire logic ack_value_bit_i,
	input wire logic irq_clear_i,
	input wire logic write_collision_flag_clear_i,
	input wire logic ov_clear_i,
	output logic buffer_full_flag_o,
	output logic ack_received_status_o,
	output logic transfer_irq_flag_o,
	output logic write_collision_flag_o,
	output logic receive_overflow_flag_o,
	output logic receive_request_o,
	output logic ack_sequence_request_o,
	output logic stop_request_o,
	output logic bus_release_seen_o,
	input wire logic scl_i,
	output logic scl_o,
	output logic scl_oe_o,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o
);
	imx_state_t st_q;
	logic [7:0] brg_q;
	logic [7:0] sh_q;
	logic [7:0] buf_q;
	logic [3:0] bit_q;
	logic scl_m_q, scl_s_q, sda_m_q, sda_s_q;
	logic scl_low_q, sda_low_q;
	logic bf_q, ack_q, irq_q, write_collision_flag_q, ov_q, receive_request_q, ack_sequence_request_q, pen_q, pseen_q;
	logic idle, brg_done, wr_take, wr_coll, rd_byte_done;
	logic [7:0] fifo_data;
	logic fifo_valid;
	logic fifo_ready;

	// the fifo takes firmware bytes; the engine pops one as soon as it is offered and sends it only when idle
	imx_fifo #(.WIDTH(IMX_BYTE_W), .DEPTH(IMX_FIFO_DEPTH)) u_fifo (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.in_data_i(wr_data_i),
		.in_valid_i(wr_valid_i),
		.in_ready_o(wr_ready_o),
		.out_data_o(fifo_data),
		.out_valid_o(fifo_valid),
		.out_ready_i(fifo_ready)
	);

	assign idle = (st_q == IMX_IDLE) || (st_q == IMX_TX_WAIT);
	assign brg_done = (brg_q == IMX_BRG_ZERO);
	// pop whenever a byte is offered: either taken, or dropped as a collision
	assign fifo_ready = fifo_valid;
	assign wr_take = fifo_valid && idle && !receive_request_q && !ack_sequence_request_q && !pen_q;
	assign wr_coll = fifo_valid && !wr_take;
	assign rd_byte_done = (st_q == IMX_RX_HIGH) && brg_done && (bit_q == IMX_BIT_LAST);

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			scl_m_q <= 1'b1;
			scl_s_q <= 1'b1;
			sda_m_q <= 1'b1;
			sda_s_q <= 1'b1;
		end else begin
			scl_m_q <= scl_i;
			scl_s_q <= scl_m_q;
			sda_m_q <= sda_i;
			sda_s_q <= sda_m_q;
		end
	end

	// baud generator: counts down, reloads on each phase change
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			brg_q <= IMX_BRG_ZERO;
		end else if (wr_take) begin
			brg_q <= baud_reload_value_i;
		end else begin
			unique case (st_q)
				IMX_TX_HIGH, IMX_RX_HIGH, IMX_ACK_HIGH, IMX_STOP_HIGH: begin
					brg_q <= (!scl_s_q || brg_done) ? baud_reload_value_i : brg_q - 8'h01;
				end
				IMX_TX_LOW, IMX_RX_LOW, IMX_ACK_LOW, IMX_STOP_LOW, IMX_STOP_END: begin
					brg_q <= brg_done ? baud_reload_value_i : brg_q - 8'h01;
				end
				default: begin
					brg_q <= baud_reload_value_i;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			st_q <= IMX_IDLE;
			bit_q <= IMX_CNT_RST;
			sh_q <= IMX_BYTE_RST;
		end else begin
			unique case (st_q)
				IMX_IDLE, IMX_TX_WAIT: begin
					bit_q <= IMX_CNT_RST;
					if (wr_take) begin
						sh_q <= fifo_data;
						st_q <= IMX_TX_LOW;
					end else if (pen_q) begin
						st_q <= IMX_STOP_SDA;
					end else if (ack_sequence_request_q) begin
						st_q <= IMX_ACK_LOW;
					end else if (receive_request_q) begin
						st_q <= IMX_RX_LOW;
					end
				end
				IMX_TX_LOW: st_q <= brg_done ? IMX_TX_HIGH : st_q;
				IMX_TX_HIGH: begin
					if (scl_s_q && brg_done) begin
						if (bit_q == IMX_BIT_ACK) begin
							st_q <= IMX_TX_WAIT;
						end else begin
							sh_q <= {sh_q[6:0], 1'b0};
							bit_q <= bit_q + 4'h1;
							st_q <= IMX_TX_LOW;
						end
					end
				end
				IMX_RX_LOW: st_q <= brg_done ? IMX_RX_HIGH : st_q;
				IMX_RX_HIGH: begin
					if (scl_s_q && brg_done) begin
						sh_q <= {sh_q[6:0], sda_s_q};
						bit_q <= bit_q + 4'h1;
						st_q <= (bit_q == IMX_BIT_LAST) ? IMX_IDLE : IMX_RX_LOW;
					end
				end
				IMX_ACK_LOW: st_q <= brg_done ? IMX_ACK_HIGH : st_q;
				IMX_ACK_HIGH: st_q <= (scl_s_q && brg_done) ? IMX_IDLE : st_q;
				IMX_STOP_SDA: st_q <= sda_s_q ? st_q : IMX_STOP_LOW;
				IMX_STOP_LOW: st_q <= brg_done ? IMX_STOP_HIGH : st_q;
				IMX_STOP_HIGH: st_q <= (scl_s_q && brg_done) ? IMX_STOP_REL : st_q;
				IMX_STOP_REL: st_q <= (sda_s_q && scl_s_q) ? IMX_STOP_END : st_q;
				IMX_STOP_END: st_q <= brg_done ? IMX_IDLE : st_q;
			endcase
		end
	end

	// line drivers: registered so the pins never glitch
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			scl_low_q <= 1'b0;
			sda_low_q <= 1'b0;
		end else begin
			unique case (st_q)
				IMX_TX_LOW: begin
					scl_low_q <= 1'b1;
					sda_low_q <= (bit_q == IMX_BIT_ACK) ? 1'b0 : !sh_q[7];
				end
				// pull scl low on the edge that ends a high phase, before sda may move
				IMX_TX_HIGH, IMX_RX_HIGH, IMX_ACK_HIGH: begin
					scl_low_q <= scl_s_q && brg_done;
				end
				IMX_STOP_HIGH: begin
					scl_low_q <= 1'b0;
				end
				IMX_RX_LOW: begin
					scl_low_q <= 1'b1;
					sda_low_q <= 1'b0;
				end
				IMX_ACK_LOW: begin
					scl_low_q <= 1'b1;
					sda_low_q <= !ack_value_bit_i;
				end
				IMX_STOP_SDA, IMX_STOP_LOW: begin
					scl_low_q <= 1'b1;
					sda_low_q <= 1'b1;
				end
				IMX_STOP_REL, IMX_STOP_END: begin
					scl_low_q <= 1'b0;
					sda_low_q <= 1'b0;
				end
				IMX_IDLE: begin
					sda_low_q <= (pen_q || ack_sequence_request_q) ? sda_low_q : 1'b0;
				end
				default: begin
					scl_low_q <= 1'b1;
				end
			endcase
		end
	end

	// open drain: the data side is always low, only the enables move
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			scl_o <= 1'b0;
			sda_o <= 1'b0;
			scl_oe_o <= 1'b0;
			sda_oe_o <= 1'b0;
		end else begin
			scl_o <= 1'b0;
			sda_o <= 1'b0;
			scl_oe_o <= scl_low_q;
			sda_oe_o <= sda_low_q;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			bf_q <= 1'b0;
			buf_q <= IMX_BYTE_RST;
		end else if (wr_take) begin
			bf_q <= 1'b1;
			buf_q <= fifo_data;
		end else if (rd_byte_done) begin
			bf_q <= 1'b1;
			buf_q <= {sh_q[6:0], sda_s_q};
		end else if (st_q == IMX_TX_HIGH && scl_s_q && brg_done && bit_q == IMX_BIT_LAST) begin
			bf_q <= 1'b0;
		end else if (buf_rd_i) begin
			bf_q <= 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			ack_q <= 1'b0;
		end else if (st_q == IMX_TX_HIGH && scl_s_q && brg_done && bit_q == IMX_BIT_ACK) begin
			ack_q <= sda_s_q;
		end
	end

	// set wins over a firmware clear in the same cycle
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			irq_q <= 1'b0;
			write_collision_flag_q <= 1'b0;
			ov_q <= 1'b0;
		end else begin
			if ((st_q == IMX_TX_HIGH && scl_s_q && brg_done && bit_q == IMX_BIT_ACK)
				|| rd_byte_done || (st_q == IMX_ACK_HIGH && scl_s_q && brg_done)
				|| (st_q == IMX_STOP_END && brg_done)) begin
				irq_q <= 1'b1;
			end else if (irq_clear_i) begin
				irq_q <= 1'b0;
			end
			if (wr_coll) begin
				write_collision_flag_q <= 1'b1;
			end else if (write_collision_flag_clear_i) begin
				write_collision_flag_q <= 1'b0;
			end
			if (rd_byte_done && bf_q && !buf_rd_i) begin
				ov_q <= 1'b1;
			end else if (ov_clear_i) begin
				ov_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			receive_request_q <= 1'b0;
			ack_sequence_request_q <= 1'b0;
			pen_q <= 1'b0;
			pseen_q <= 1'b0;
		end else begin
			if (rd_byte_done) begin
				receive_request_q <= 1'b0;
			end else if (receive_request_set_i && idle && !ack_sequence_request_q && !pen_q) begin
				receive_request_q <= 1'b1;
			end
			if (st_q == IMX_ACK_HIGH && scl_s_q && brg_done) begin
				ack_sequence_request_q <= 1'b0;
			end else if (ack_sequence_request_set_i && idle && !receive_request_q && !pen_q) begin
				ack_sequence_request_q <= 1'b1;
			end
			if (st_q == IMX_STOP_END && brg_done) begin
				pen_q <= 1'b0;
			end else if (stop_request_set_i && idle && !receive_request_q && !ack_sequence_request_q) begin
				pen_q <= 1'b1;
				pseen_q <= 1'b0;
			end
			if (st_q == IMX_STOP_REL && sda_s_q && scl_s_q) begin
				pseen_q <= 1'b1;
			end
		end
	end

	assign tx_rx_buffer_o = buf_q;
	assign buffer_full_flag_o = bf_q;
	assign ack_received_status_o = ack_q;
	assign transfer_irq_flag_o = irq_q;
	assign write_collision_flag_o = write_collision_flag_q;
	assign receive_overflow_flag_o = ov_q;
	assign receive_request_o = receive_request_q;
	assign ack_sequence_request_o = ack_sequence_request_q;
	assign stop_request_o = pen_q;
	assign bus_release_seen_o = pseen_q;

	a_rx_not_idle: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(receive_request_set_i && !idle && !receive_request_q) |=> !receive_request_q)
		else $error("receive request accepted while busy");
	a_coll_flag: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		wr_coll |=> write_collision_flag_q)
		else $error("collision not flagged");
	a_coll_keep: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(wr_coll && !rd_byte_done) |=> $stable(buf_q))
		else $error("buffer changed on dropped write");
	a_tx_start: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		wr_take |=> bf_q && st_q == IMX_TX_LOW)
		else $error("write did not start transmit");
	a_rx_done: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		rd_byte_done |=> bf_q && irq_q && !receive_request_q && st_q == IMX_IDLE)
		else $error("receive completion wrong");
	a_stretch_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(st_q == IMX_TX_HIGH && !scl_s_q) |=> st_q == IMX_TX_HIGH)
		else $error("generator ran during clock stretch");
	sequence s_ack_park;
		!ack_sequence_request_q && st_q == IMX_IDLE ##1 scl_oe_o;
	endsequence
	a_ack_idle: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(st_q == IMX_ACK_HIGH && scl_s_q && brg_done) |=> s_ack_park)
		else $error("ack sequence did not end");
	a_stop_irq: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(st_q == IMX_STOP_END && brg_done) |=> irq_q && !pen_q && pseen_q)
		else $error("stop completion wrong");
endmodule // imx_master
`default_nettype wire

// >>> verification/imx_slave_model.sv
`timescale 1ns/1ps
`default_nettype none
module imx_slave_model (
	input wire logic clk_i,
	input wire logic scl_i,
	input wire logic sda_i,
	input wire logic read_i,
	input wire logic ack_i,
	input wire logic stretch_i,
	input wire logic [7:0] tx_byte_i,
	output logic scl_pull_o,
	output logic sda_pull_o,
	output logic [7:0] rx_byte_o,
	output logic ack_seen_o
);
	logic scl_q = 1'b1;
	logic [3:0] cnt_q = 4'h0;
	logic [4:0] hold_q = 5'h00;
	logic drv_q = 1'b0;
	logic [7:0] rx_q = 8'h00;
	logic ack_seen_q = 1'b0;
	assign rx_byte_o = rx_q;
	assign ack_seen_o = ack_seen_q;
	always_ff @(posedge clk_i) begin
		scl_q <= scl_i;
		if (scl_i && !scl_q) begin
			cnt_q <= cnt_q + 4'h1;
			if (cnt_q < 4'h8) begin
				rx_q <= {rx_q[6:0], sda_i};
			end else begin
				ack_seen_q <= sda_i;
			end
		end else if (!scl_i && scl_q && cnt_q == 4'h9) begin
			cnt_q <= 4'h0;
		end
	end
	// stretching after each falling edge makes the master wait
	always_ff @(posedge clk_i) begin
		if (!scl_i && scl_q && stretch_i) begin
			hold_q <= 5'h14;
		end else if (hold_q != 5'h00) begin
			hold_q <= hold_q - 5'h01;
		end
	end
	// read data only moves while scl is low
	always_ff @(posedge clk_i) begin
		if (!scl_i) begin
			drv_q <= read_i && cnt_q < 4'h8 && !tx_byte_i[3'h7 - cnt_q[2:0]];
		end
	end
	assign scl_pull_o = hold_q != 5'h00;
	assign sda_pull_o = drv_q || (ack_i && !read_i && ((cnt_q == 4'h8 && !scl_i) || cnt_q == 4'h9));
endmodule // imx_slave_model
`default_nettype wire

// >>> verification/i2c_master_xfer_ack_stop_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module i2c_master_xfer_ack_stop_tb_top;
	logic clk_i, rst_n_i, wr_valid_i, wr_ready_o, buf_rd_i, ack_value_bit_i;
	logic [7:0] wr_data_i, tx_rx_buffer_o, baud_reload_value_i, s_tx, s_rx;
	logic receive_request_set_i, ack_sequence_request_set_i, stop_request_set_i;
	logic irq_clear_i, write_collision_flag_clear_i, ov_clear_i, buffer_full_flag_o, ack_received_status_o;
	logic transfer_irq_flag_o, write_collision_flag_o, receive_overflow_flag_o;
	logic receive_request_o, ack_sequence_request_o, stop_request_o, bus_release_seen_o;
	logic scl_i, scl_o, scl_oe_o, sda_i, sda_o, sda_oe_o;
	logic s_read, s_ack, s_str, s_scl, s_sda, s_ackseen;
	int mismatches = 0;
	int total_checks = 0;
	int hi_cnt = 0;
	assign scl_i = !(scl_oe_o || s_scl);
	assign sda_i = !(sda_oe_o || s_sda);
	imx_master i_dut (.clk_i, .rst_n_i, .wr_data_i, .wr_valid_i, .wr_ready_o, .buf_rd_i,
		.tx_rx_buffer_o, .baud_reload_value_i, .receive_request_set_i,
		.ack_sequence_request_set_i, .stop_request_set_i, .ack_value_bit_i, .irq_clear_i,
		.write_collision_flag_clear_i, .ov_clear_i, .buffer_full_flag_o, .ack_received_status_o,
		.transfer_irq_flag_o, .write_collision_flag_o, .receive_overflow_flag_o,
		.receive_request_o, .ack_sequence_request_o, .stop_request_o, .bus_release_seen_o,
		.scl_i, .scl_o, .scl_oe_o, .sda_i, .sda_o, .sda_oe_o);
	imx_slave_model i_slave (.clk_i, .scl_i, .sda_i, .read_i(s_read), .ack_i(s_ack),
		.stretch_i(s_str), .tx_byte_i(s_tx), .scl_pull_o(s_scl), .sda_pull_o(s_sda),
		.rx_byte_o(s_rx), .ack_seen_o(s_ackseen));
	initial begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end
	task automatic tick(input int n = 1);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		total_checks++;
		if (g !== e) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic put(input logic [7:0] b);
		wr_data_i = b;
		wr_valid_i = 1'b1;
		tick();
		wr_valid_i = 1'b0;
		tick();
	endtask
	task automatic wait_irq();
		int k;
		for (k = 0; k < 3000 && transfer_irq_flag_o !== 1'b1; k++) tick();
		chk("irq", 8'h01, {7'h00, transfer_irq_flag_o});
		irq_clear_i = 1'b1;
		tick();
		irq_clear_i = 1'b0;
		tick(3);
	endtask
	task automatic conclude();
		if (mismatches == 0 && total_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// every high phase of scl lasts at least one baud period
	always @(posedge clk_i) begin
		if (scl_i) begin
			hi_cnt <= hi_cnt + 1;
		end else begin
			if (hi_cnt != 0 && hi_cnt < 32'(baud_reload_value_i) + 1) begin
				mismatches++;
				$display("mismatch scl_high expected %0d seen %0d", baud_reload_value_i + 1, hi_cnt);
			end
			hi_cnt <= 0;
		end
	end
	initial begin
		repeat (20000) @(posedge clk_i);
		mismatches++;
		conclude();
	end
	initial begin
		{rst_n_i, wr_valid_i, buf_rd_i, ack_value_bit_i, receive_request_set_i} = 5'h00;
		{ack_sequence_request_set_i, stop_request_set_i, irq_clear_i, write_collision_flag_clear_i} = 4'h0;
		{ov_clear_i, s_read, s_ack, s_str} = 4'h0;
		wr_data_i = 8'h00;
		s_tx = 8'h00;
		baud_reload_value_i = 8'h03;
		tick(16);
		rst_n_i = 1'b1;
		tick();
		chk("reset_flags", 8'h00, {buffer_full_flag_o, ack_received_status_o,
			transfer_irq_flag_o, write_collision_flag_o, receive_overflow_flag_o,
			receive_request_o, ack_sequence_request_o, stop_request_o});
		chk("reset_pins", 8'h08, {2'h0, scl_o, sda_o, wr_ready_o, bus_release_seen_o, scl_oe_o,
			sda_oe_o});
		s_ack = 1'b1;
		put(8'hA5);
		tick(4);
		chk("bf_tx", 8'h01, {7'h00, buffer_full_flag_o});
		put(8'h55);
		tick(4);
		chk("write_collision_flag_tx", 8'h01, {7'h00, write_collision_flag_o});
		receive_request_set_i = 1'b1;
		tick();
		receive_request_set_i = 1'b0;
		tick(3);
		chk("rcv_busy", 8'h00, {7'h00, receive_request_o});
		wait_irq();
		chk("addr", 8'hA5, s_rx);
		chk("ackstat0", 8'h00, {7'h00, ack_received_status_o});
		chk("bf_done", 8'h00, {7'h00, buffer_full_flag_o});
		chk("write_collision_flag_kept", 8'h01, {7'h00, write_collision_flag_o});
		tick(20);
		chk("scl_hold", 8'h01, {7'h00, scl_oe_o});
		write_collision_flag_clear_i = 1'b1;
		tick();
		write_collision_flag_clear_i = 1'b0;
		{s_ack, s_str} = 2'b01;
		put(8'h3C);
		wait_irq();
		chk("data", 8'h3C, s_rx);
		chk("ackstat1", 8'h01, {7'h00, ack_received_status_o});
		{s_read, s_str, s_tx} = {2'b10, 8'h96};
		receive_request_set_i = 1'b1;
		tick();
		receive_request_set_i = 1'b0;
		tick(6);
		put(8'h11);
		tick(4);
		chk("write_collision_flag_rx", 8'h01, {7'h00, write_collision_flag_o});
		wait_irq();
		chk("rx_byte", 8'h96, tx_rx_buffer_o);
		chk("rx_flags", 8'h02, {6'h00, buffer_full_flag_o, receive_request_o});
		ack_sequence_request_set_i = 1'b1;
		tick();
		ack_sequence_request_set_i = 1'b0;
		tick(3);
		chk("ack_drive", 8'h03, {6'h00, scl_oe_o, sda_oe_o});
		wait_irq();
		chk("ack_sent", 8'h00, {6'h00, s_ackseen, ack_sequence_request_o});
		s_tx = 8'h69;
		receive_request_set_i = 1'b1;
		tick();
		receive_request_set_i = 1'b0;
		wait_irq();
		chk("overflow", 8'h01, {7'h00, receive_overflow_flag_o});
		buf_rd_i = 1'b1;
		tick();
		buf_rd_i = 1'b0;
		tick(3);
		chk("bf_read", 8'h00, {7'h00, buffer_full_flag_o});
		ack_value_bit_i = 1'b1;
		ack_sequence_request_set_i = 1'b1;
		tick();
		ack_sequence_request_set_i = 1'b0;
		wait_irq();
		chk("nack_sent", 8'h01, {7'h00, s_ackseen});
		s_read = 1'b0;
		stop_request_set_i = 1'b1;
		tick();
		stop_request_set_i = 1'b0;
		tick(3);
		chk("stop_sda", 8'h01, {7'h00, sda_oe_o});
		wait_irq();
		chk("stop_end", 8'h0D, {4'h0, bus_release_seen_o, scl_i, stop_request_o, sda_i});
		conclude();
	end
endmodule // i2c_master_xfer_ack_stop_tb_top
`default_nettype wire
